// >>> core/dcp_cfg.svh
// dcp_cfg.svh: offsets, field positions, reset values and timing for the default pipe block
// assumes: included by its bare name from the package file only; the design module has no include of its own
`ifndef DCP_CFG_SVH
`define DCP_CFG_SVH
`define DCP_OFS_MAXP       8'h5E
`define DCP_OFS_CTRL       8'h60
`define DCP_OFS_CONFIG     8'h62
`define DCP_OFS_IRQ_STAT   8'h70
`define DCP_OFS_IRQ_MASK   8'h72
`define DCP_CFG_CONT_BIT   8
`define DCP_CFG_DIR_BIT    4
`define DCP_MXP_SEL_HI     15
`define DCP_MXP_SEL_LO     14
`define DCP_MXP_SIZE_HI    6
`define DCP_MXP_SIZE_LO    3
`define DCP_MXP_RESET      4'h8
`define DCP_CTL_BUF_BIT    15
`define DCP_CTL_SETUP_BIT  14
`define DCP_CTL_CLR_BIT    8
`define DCP_CTL_SET_BIT    7
`define DCP_CTL_MON_BIT    6
`define DCP_CTL_CPL_BIT    2
`define DCP_CTL_RSP_HI     1
`define DCP_CTL_RSP_LO     0
`define DCP_IRQ_SETUP_RX   0
`define DCP_IRQ_SETUP_DONE 1
`define DCP_IRQ_XFER_ERR   2
`define DCP_IRQ_WIDTH      3
`define DCP_RSP_NAK        2'h0
`define DCP_RSP_BUF        2'h1
`define DCP_RSP_STALL      2'h2
`define DCP_TOGGLE_GAP_NS  200
`define DCP_CLK_NS         40
`endif

// >>> core/dcp_pkg.sv
// dcp_pkg.sv: types shared by the default control pipe register block
// assumes: dcp_cfg.svh on the include path
`include "dcp_cfg.svh"
package dcp_pkg;
   typedef logic [15:0] dcp_word_t;
   typedef logic [1:0]  dcp_rsp_t;
endpackage

// >>> core/dcp_regs.sv
// dcp_regs.sv: config, max-packet and control registers of the default control pipe
// assumes: one clock mclk, sync active-low reset, a plain register port with
// read data one cycle after the read strobe, and a link engine driving the event inputs
//
// Contract
// - continuous-mode bit 8 of config: 0 non-continuous, 1 continuous, resets 0.
// - one continuous setting serves both transfer directions of the pipe.
// - host-mode direction bit 4: 0 receive, 1 send.
// - device-select bits 15:14 choose target address 0..3, reset 0.
// - max-packet resets 64; bits 2:0 read zero, ignore writes.
// - read-only bit 15 shows buffer accessible, direction per port way select.
// - writing 1 to bit 14 requests SETUP send; hardware clears when sent.
// - bit 8 forces DATA0, bit 7 DATA1; both read zero.
// - toggle monitor bit 6, resets 1, set by SETUP token in peripheral mode.
// - peripheral writing 1 to bit 2 ends control transfer; reads zero.
// - SETUP token clears transfer-complete in peripheral mode; host keeps it 0.
// - response bits 1:0: 00 NAK, 01 buffer, 1x STALL; reset 00.
// - SETUP token clears response to NAK; errors let hardware set response.
// - host sends request registers in SETUP; peripheral stores received fields; this block has no request registers.
`timescale 1ns/100ps
module dcp_regs
   import dcp_pkg::*;
#(
   parameter int TOGGLE_GAP_NS = `DCP_TOGGLE_GAP_NS
) (
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   input  wire logic        host_mode,
   input  wire logic        buffer_ready,
   input  wire logic        buffer_port_way_sel,
   input  wire logic        setup_token_rx,
   input  wire logic        setup_sent,
   input  wire logic        toggle_update,
   input  wire logic        toggle_value,
   input  wire logic        xfer_error,
   input  wire logic [1:0]  error_response,
   output logic             continuous_xfer_sel,
   output logic             pipe_send_dir,
   output logic      [1:0]  target_device_sel,
   output logic      [6:0]  max_packet_bytes,
   output logic             setup_send_request,
   output logic             toggle_force_data0,
   output logic             toggle_force_data1,
   output logic             toggle_monitor,
   output logic             ctrl_xfer_complete,
   output logic      [1:0]  handshake_response_sel,
   output logic             buffer_dir_write,
   output logic             toggle_gap_ok,
   output logic             irq
);
   localparam int GAP_CYC = (TOGGLE_GAP_NS + `DCP_CLK_NS - 1) / `DCP_CLK_NS;

   logic        cont_q,  cont_d;
   logic        dir_q,   dir_d;
   logic [1:0]  dsel_q,  dsel_d;
   logic [3:0]  mxp_q,   mxp_d;
   logic        sreq_q,  sreq_d;
   logic        mon_q,   mon_d;
   dcp_rsp_t    rsp_q,   rsp_d;
   logic        clr_q,   set_q,  cpl_q;
   logic [`DCP_IRQ_WIDTH-1:0] ist_q, ist_d, imsk_q, ev;
   logic [7:0]  gap_q,   gap_d;
   dcp_word_t   rdata_q, rdata_d;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   wire         wr_cfg   = reg_wr && hit(reg_addr, `DCP_OFS_CONFIG);
   wire         wr_mxp   = reg_wr && hit(reg_addr, `DCP_OFS_MAXP);
   wire         wr_ctl   = reg_wr && hit(reg_addr, `DCP_OFS_CTRL);
   wire         wr_ist   = reg_wr && hit(reg_addr, `DCP_OFS_IRQ_STAT);
   wire         wr_imsk  = reg_wr && hit(reg_addr, `DCP_OFS_IRQ_MASK);
   wire         periph_setup = setup_token_rx && !host_mode;
   wire         frc0     = wr_ctl && reg_wdata[`DCP_CTL_CLR_BIT];
   wire         frc1     = wr_ctl && reg_wdata[`DCP_CTL_SET_BIT];
   // peripheral-only end of transfer; host writes are dropped
   wire         cpl_wr   = wr_ctl && reg_wdata[`DCP_CTL_CPL_BIT] && !host_mode;

   // one bit for both directions, no per-direction copy
   assign cont_d = wr_cfg ? reg_wdata[`DCP_CFG_CONT_BIT] : cont_q;
   assign dir_d  = wr_cfg ? reg_wdata[`DCP_CFG_DIR_BIT] : dir_q;
   assign dsel_d = wr_mxp ? reg_wdata[`DCP_MXP_SEL_HI:`DCP_MXP_SEL_LO] : dsel_q;
   assign mxp_d  = wr_mxp ? reg_wdata[`DCP_MXP_SIZE_HI:`DCP_MXP_SIZE_LO] : mxp_q;
   // sent wins only when no new request is written in the same cycle
   assign sreq_d = (wr_ctl && reg_wdata[`DCP_CTL_SETUP_BIT]) ? 1'b1 :
                   setup_sent ? 1'b0 : sreq_q;
   // setup token beats a force write: hardware must land on DATA1
   assign mon_d  = periph_setup ? 1'b1 :
                   frc0 ? 1'b0 :
                   frc1 ? 1'b1 :
                   toggle_update ? toggle_value : mon_q;
   assign rsp_d  = periph_setup ? `DCP_RSP_NAK :
                   xfer_error ? error_response :
                   wr_ctl ? reg_wdata[`DCP_CTL_RSP_HI:`DCP_CTL_RSP_LO] : rsp_q;

   assign ev[`DCP_IRQ_SETUP_RX]   = periph_setup;
   assign ev[`DCP_IRQ_SETUP_DONE] = setup_sent && sreq_q;
   assign ev[`DCP_IRQ_XFER_ERR]   = xfer_error;
   // new event wins over a write-one clear in the same cycle
   assign ist_d  = ev | (ist_q & ~(wr_ist ? reg_wdata[`DCP_IRQ_WIDTH-1:0] : '0));

   assign gap_d  = (frc0 || frc1) ? GAP_CYC[7:0] :
                   (gap_q != 8'h00) ? gap_q - 8'h01 : gap_q;

   wire [15:0] cfg_rd = {7'h00, cont_q, 3'h0, dir_q, 4'h0};
   wire [15:0] mxp_rd = {dsel_q, 7'h00, mxp_q, 3'h0};
   // force bits and complete bit always read back as zero
   wire [15:0] ctl_rd = {buffer_ready, sreq_q, 5'h00, 1'b0, 1'b0, mon_q,
                         3'h0, 1'b0, rsp_q};

   always_comb begin
      if (!reg_rd) begin
         rdata_d = rdata_q;
      end else if (hit(reg_addr, `DCP_OFS_CONFIG)) begin
         rdata_d = cfg_rd;
      end else if (hit(reg_addr, `DCP_OFS_MAXP)) begin
         rdata_d = mxp_rd;
      end else if (hit(reg_addr, `DCP_OFS_CTRL)) begin
         rdata_d = ctl_rd;
      end else if (hit(reg_addr, `DCP_OFS_IRQ_STAT)) begin
         rdata_d = {13'h0000, ist_q};
      end else if (hit(reg_addr, `DCP_OFS_IRQ_MASK)) begin
         rdata_d = {13'h0000, imsk_q};
      end else begin
         rdata_d = 16'h0000;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cont_q  <= 1'b0;
         dir_q   <= 1'b0;
         dsel_q  <= 2'h0;
         mxp_q   <= `DCP_MXP_RESET;
         sreq_q  <= 1'b0;
         mon_q   <= 1'b1;
         rsp_q   <= `DCP_RSP_NAK;
      end else begin
         cont_q  <= cont_d;
         dir_q   <= dir_d;
         dsel_q  <= dsel_d;
         mxp_q   <= mxp_d;
         sreq_q  <= sreq_d;
         mon_q   <= mon_d;
         rsp_q   <= rsp_d;
      end
   end

   // force and complete strobes are one-cycle pulses to the link engine
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         clr_q   <= 1'b0;
         set_q   <= 1'b0;
         cpl_q   <= 1'b0;
         gap_q   <= 8'h00;
      end else begin
         clr_q   <= frc0;
         set_q   <= frc1;
         cpl_q   <= cpl_wr && !periph_setup;
         gap_q   <= gap_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ist_q   <= '0;
         imsk_q  <= '0;
         rdata_q <= 16'h0000;
      end else begin
         ist_q   <= ist_d;
         imsk_q  <= wr_imsk ? reg_wdata[`DCP_IRQ_WIDTH-1:0] : imsk_q;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata              = rdata_q;
   assign continuous_xfer_sel    = cont_q;
   // peripheral mode never sends on its own direction bit; host_mode gates it to 0
   assign pipe_send_dir          = dir_q && host_mode;
   // target address used for SETUP taken from max-packet register bits 15:14
   assign target_device_sel      = dsel_q;
   assign max_packet_bytes       = {mxp_q, 3'h0};
   assign setup_send_request     = sreq_q;
   assign toggle_force_data0     = clr_q;
   assign toggle_force_data1     = set_q;
   assign toggle_monitor         = mon_q;
   assign ctrl_xfer_complete     = cpl_q;
   assign handshake_response_sel = rsp_q;
   assign buffer_dir_write       = buffer_port_way_sel;
   assign toggle_gap_ok          = (gap_q == 8'h00);
   assign irq                    = |(ist_q & imsk_q);
endmodule // dcp_regs

// >>> tb/dcp_link_model.sv
// dcp_link_model.sv: stand-in for the link engine facing the far USB party
// assumes: the bench commands tokens and errors; a SETUP request is sent after a few cycles
`timescale 1ns/100ps
module dcp_link_model #(parameter int SENT_DLY = 3) (
   input  wire logic mclk,
   input  wire logic nrst,
   input  wire logic host_mode,
   input  wire logic setup_send_request,
   input  wire logic rx_cmd,
   input  wire logic err_cmd,
   output logic      setup_token_rx,
   output logic      setup_sent,
   output logic      xfer_error,
   output logic      toggle_update,
   output logic      toggle_value
);
   logic [3:0] cnt_q;
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cnt_q <= 4'h0;
         setup_sent <= 1'b0;
         setup_token_rx <= 1'b0;
         xfer_error <= 1'b0;
         toggle_update <= 1'b0;
         toggle_value <= 1'b0;
      end else begin
         cnt_q <= (host_mode && setup_send_request && !setup_sent) ? cnt_q + 4'h1 : 4'h0;
         setup_sent <= cnt_q == SENT_DLY[3:0];
         setup_token_rx <= rx_cmd && !host_mode;
         xfer_error <= err_cmd;
         toggle_update <= err_cmd;
         toggle_value <= toggle_value ^ err_cmd;
      end
   end
endmodule // dcp_link_model

// >>> tb/dcp_regs_props.sv
// dcp_regs_props.sv: port-level assertions for the default pipe registers
// assumes: bound to dcp_regs from the bench top file
`timescale 1ns/100ps
module dcp_regs_props (
   input wire logic        mclk,
   input wire logic        nrst,
   input wire logic [7:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        host_mode,
   input wire logic        setup_token_rx,
   input wire logic        setup_sent,
   input wire logic        continuous_xfer_sel,
   input wire logic        pipe_send_dir,
   input wire logic [6:0]  max_packet_bytes,
   input wire logic        setup_send_request,
   input wire logic        toggle_force_data0,
   input wire logic        toggle_monitor,
   input wire logic        ctrl_xfer_complete,
   input wire logic [1:0]  handshake_response_sel
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   wire ctl_wr = reg_wr && reg_addr == 8'h60;
   wire tok    = setup_token_rx && !host_mode;
   a_cont_load: assert property (reg_wr && reg_addr == 8'h62
      |=> continuous_xfer_sel == $past(reg_wdata[8])) else $error("continuous bit not loaded");
   a_dir_host: assert property (pipe_send_dir |-> host_mode)
      else $error("send direction outside host mode");
   a_mxp_low: assert property (max_packet_bytes[2:0] == 3'h0)
      else $error("packet size low bits not zero");
   a_sreq_clear: assert property (setup_sent && !(ctl_wr && reg_wdata[14])
      |=> !setup_send_request) else $error("setup request not cleared");
   a_force0_pulse: assert property (ctl_wr && reg_wdata[8] && !tok
      |=> toggle_force_data0 ##1 !toggle_force_data0) else $error("force pulse wrong");
   a_mon_setup: assert property (tok |=> toggle_monitor)
      else $error("monitor not set by token");
   a_cpl_token: assert property (tok |=> !ctrl_xfer_complete)
      else $error("complete pulse beside token");
   a_rsp_token: assert property (tok |=> handshake_response_sel == 2'h0)
      else $error("response not cleared by token");
endmodule // dcp_regs_props

// >>> tb/default_control_pipe_regs_tb.sv
// default_control_pipe_regs_tb.sv: self-checking bench for dcp_regs
// assumes: link model and checker files compiled before this one
`timescale 1ns/100ps
module default_control_pipe_regs_tb;
   import dcp_pkg::*;
   logic mclk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, host_mode = 1'b1;
   logic buffer_ready = 1'b0, way_sel = 1'b0, rx_cmd = 1'b0, err_cmd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [1:0] error_response = 2'h0, dsel, rsp;
   logic [6:0] mxp;
   dcp_word_t  reg_wdata = 16'h0000, reg_rdata, d;
   logic cont, dir, sreq, f0, f1, mon, cpl, bdir, gap, irq, tok, sent, xerr, tupd, tval;
   int n_mismatch = 0, total_checks = 0;
   always #20 mclk = ~mclk;
   dcp_regs u_dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_mode(host_mode),
      .buffer_ready(buffer_ready), .buffer_port_way_sel(way_sel), .setup_token_rx(tok),
      .setup_sent(sent), .toggle_update(tupd), .toggle_value(tval), .xfer_error(xerr),
      .error_response(error_response), .continuous_xfer_sel(cont), .pipe_send_dir(dir),
      .target_device_sel(dsel), .max_packet_bytes(mxp), .setup_send_request(sreq),
      .toggle_force_data0(f0), .toggle_force_data1(f1), .toggle_monitor(mon),
      .ctrl_xfer_complete(cpl), .handshake_response_sel(rsp), .buffer_dir_write(bdir),
      .toggle_gap_ok(gap), .irq(irq));
   dcp_link_model u_link (.mclk(mclk), .nrst(nrst), .host_mode(host_mode),
      .setup_send_request(sreq), .rx_cmd(rx_cmd), .err_cmd(err_cmd), .setup_token_rx(tok),
      .setup_sent(sent), .xfer_error(xerr), .toggle_update(tupd), .toggle_value(tval));
   task automatic chk(string nm, dcp_word_t e, dcp_word_t g);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(logic [7:0] a, dcp_word_t v);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(logic [7:0] a, dcp_word_t e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk("rdata", e, reg_rdata);
   endtask
   task automatic pulse_in(logic sel);
      @(posedge mclk);
      if (sel) err_cmd <= 1'b1;
      else rx_cmd <= 1'b1;
      @(posedge mclk);
      err_cmd <= 1'b0;
      rx_cmd <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
   endtask
   function automatic dcp_word_t exp_ctl(logic b, logic m, logic [1:0] r);
      return {b, 1'b0, 7'h00, m, 3'h0, 1'b0, r};
   endfunction
   task automatic test_done;
      if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      void'($urandom(28214));
      repeat (5) @(posedge mclk);
      nrst <= 1'b1;
      rd(8'h5E, 16'h0040);
      rd(8'h60, exp_ctl(1'b0, 1'b1, 2'h0));
      rd(8'h62, 16'h0000);
      rd(8'h7E, 16'h0000);
      for (int i = 0; i < 20; i++) begin
         d = $urandom;
         buffer_ready <= d[1];
         way_sel <= d[0];
         wr(8'h62, d);
         chk("dir", 16'(d[4]), 16'(dir));
         chk("bdir", 16'(d[0]), 16'(bdir));
         chk("cont", 16'(d[8]), 16'(cont));
         rd(8'h62, d & 16'h0110);
         wr(8'h5E, d);
         chk("dsel", 16'(d[15:14]), 16'(dsel));
         chk("mxp", 16'({d[6:3], 3'h0}), 16'(mxp));
         rd(8'h5E, d & 16'hC078);
         rd(8'h60, exp_ctl(d[1], 1'b1, 2'h0));
      end
      buffer_ready <= 1'b0;
      wr(8'h62, 16'h0000);
      wr(8'h5E, 16'h0040);
      wr(8'h72, 16'h0007);
      wr(8'h60, 16'h4000);
      chk("sreq", 16'h0001, 16'(sreq));
      repeat (8) @(posedge mclk);
      #1;
      chk("sreq", 16'h0000, 16'(sreq));
      chk("irq", 16'h0001, 16'(irq));
      wr(8'h70, 16'h0002);
      chk("irq", 16'h0000, 16'(irq));
      wr(8'h60, 16'h0100);
      chk("mon", 16'h0000, 16'(mon));
      chk("f0", 16'h0001, 16'(f0));
      chk("gap", 16'h0000, 16'(gap));
      repeat (5) @(posedge mclk);
      #1;
      chk("gap", 16'h0001, 16'(gap));
      wr(8'h60, 16'h0080);
      chk("f1", 16'h0001, 16'(f1));
      rd(8'h60, exp_ctl(1'b0, 1'b1, 2'h0));
      host_mode <= 1'b0;
      wr(8'h60, 16'h0004);
      chk("cpl", 16'h0001, 16'(cpl));
      for (int r = 1; r < 4; r++) begin
         wr(8'h60, 16'(r));
         rd(8'h60, exp_ctl(1'b0, 1'b1, 2'(r)));
      end
      wr(8'h60, 16'h0000);
      wr(8'h60, 16'h0100);
      wr(8'h60, 16'h0001);
      pulse_in(1'b0);
      rd(8'h60, exp_ctl(1'b0, 1'b1, 2'h0));
      chk("irq", 16'h0001, 16'(irq));
      error_response <= 2'h2;
      pulse_in(1'b1);
      chk("rsp", 16'h0002, 16'(rsp));
      wr(8'h70, 16'h0007);
      chk("irq", 16'h0000, 16'(irq));
      test_done;
   end
   initial begin
      #400000;
      n_mismatch++;
      test_done;
   end
endmodule // default_control_pipe_regs_tb
bind dcp_regs dcp_regs_props u_props (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .host_mode(host_mode),
   .setup_token_rx(setup_token_rx), .setup_sent(setup_sent),
   .continuous_xfer_sel(continuous_xfer_sel), .pipe_send_dir(pipe_send_dir),
   .max_packet_bytes(max_packet_bytes), .setup_send_request(setup_send_request),
   .toggle_force_data0(toggle_force_data0), .toggle_monitor(toggle_monitor),
   .ctrl_xfer_complete(ctrl_xfer_complete), .handshake_response_sel(handshake_response_sel));
